// file: src/rx_clk_div_pkg.sv
// Constants and types for the receive clock divider and SRTS transmit
// configuration block.
// Assumes a 16-bit register port addressed by the printed byte offsets.
package rx_clk_div_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Register offsets
   localparam logic [15:0] OFF_BASE_DIVISOR = 16'h60a8;
   localparam logic [15:0] OFF_SPLIT_COUNT = 16'h60aa;
   localparam logic [15:0] OFF_DIV_STATUS = 16'h60ae;
   localparam logic [15:0] OFF_TX_SPACING_CH = 16'h60b0;
   localparam logic [15:0] OFF_TX_BYTE_NUMBER = 16'h60b2;

   // Field widths and positions
   localparam int unsigned BASE_W = 14;
   localparam int unsigned SPLIT_W = 12;
   localparam int unsigned CNT_W = 15;
   localparam int unsigned SPACING_W = 8;
   localparam int unsigned SPACING_LSB = 0;
   localparam int unsigned CHANNELS_W = 7;
   localparam int unsigned CHANNELS_LSB = 8;
   localparam int unsigned BYTE_NUM_W = 9;

   // Reset values
   localparam logic [15:0] RST_SPLIT_COUNT = 16'h0fff;
   localparam logic [15:0] RST_TX_SPACING_CH = 16'h0000;
   localparam logic [8:0] RST_TX_BYTE_NUMBER = 9'h177;

   // Divider constants
   localparam logic [SPLIT_W-1:0] SPLIT_ZERO = 12'h000;
   localparam logic [SPLIT_W-1:0] SPLIT_MIN = 12'h001;
   localparam logic [CNT_W-1:0] SHORT_ADD = 15'h0002;
   localparam logic [CNT_W-1:0] LONG_ADD = 15'h0003;
   localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
   localparam logic [SPLIT_W-1:0] STEP_ONE = 12'h001;

   // SRTS transmit settings handed to the transmit path
   typedef struct packed {
      logic [CHANNELS_W-1:0] channels_m1;
      logic [SPACING_W-1:0] spacing;
      logic [BYTE_NUM_W-1:0] byte_number;
   } srts_tx_cfg_s;

endpackage

// file: src/rx_clock_divider_srts_tx_cfg.sv
// Fractional divider producing the recovered virtual clock pulse from the
// master clock, plus the SRTS transmit configuration registers.
// Assumes a synchronous 16-bit register port on i_clk; all inputs except
// i_nrst come from logic on the same clock.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// Functional notes
// - 14-bit base divisor in low field divides master clock with split count.
// - Per 4096 divisions: split count times base+2, rest base+3.
// - Split one gives one base+2 then 4095 base+3; short first.
// - Split count zero is illegal; hardware treats it as one.
// - 8-bit spacing sets gap of derived byte clock pulses.
// - 7-bit channel count minus one; codes 7a to 7f reserved.
// - 9-bit payload byte count per eight cells, e.g. 376 or 375.
// - Byte number bits 15:9 read zero and ignore writes.
module rx_clock_divider_srts_tx_cfg
   import rx_clk_div_pkg::*;
#(
   // Reset value not given; plain default
   parameter logic [15:0] RST_BASE_DIVISOR = 16'h0000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [rx_clk_div_pkg::ADDR_W-1:0] i_addr,
   input wire logic [rx_clk_div_pkg::DATA_W-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [rx_clk_div_pkg::DATA_W-1:0] o_rd_data,
   // Divider output and transmit settings
   output logic o_recovered_virtual_clock,
   output rx_clk_div_pkg::srts_tx_cfg_s o_tx_cfg
);
   import rx_clk_div_pkg::*;

   logic rst_meta_q;
   logic rst_sync_q;
   logic [15:0] base_divisor_q;
   logic [15:0] split_count_q;
   logic [15:0] tx_spacing_ch_q;
   logic [BYTE_NUM_W-1:0] tx_byte_number_q;
   logic [DATA_W-1:0] rd_data_q;
   logic [CNT_W-1:0] cnt_q;
   logic [SPLIT_W-1:0] step_q;
   logic pulse_q;
   logic [SPLIT_W-1:0] split_eff;
   logic short_div;
   logic [CNT_W-1:0] div_len;
   logic div_end;

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Register writes; reserved R/W bits are kept as written
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         base_divisor_q <= RST_BASE_DIVISOR;
         split_count_q <= RST_SPLIT_COUNT;
         tx_spacing_ch_q <= RST_TX_SPACING_CH;
         tx_byte_number_q <= RST_TX_BYTE_NUMBER;
      end else if (i_wr) begin
         case (i_addr)
            OFF_BASE_DIVISOR: begin
               base_divisor_q <= i_wr_data;
            end
            OFF_SPLIT_COUNT: begin
               split_count_q <= i_wr_data;
            end
            OFF_TX_SPACING_CH: begin
               tx_spacing_ch_q <= i_wr_data;
            end
            OFF_TX_BYTE_NUMBER: begin
               tx_byte_number_q <= i_wr_data[BYTE_NUM_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rd_data_q <= '0;
      end else if (i_rd) begin
         case (i_addr)
            OFF_BASE_DIVISOR: begin
               rd_data_q <= base_divisor_q;
            end
            OFF_SPLIT_COUNT: begin
               rd_data_q <= split_count_q;
            end
            OFF_DIV_STATUS: begin
               rd_data_q <= {{(DATA_W-SPLIT_W){1'b0}}, step_q};
            end
            OFF_TX_SPACING_CH: begin
               rd_data_q <= tx_spacing_ch_q;
            end
            OFF_TX_BYTE_NUMBER: begin
               rd_data_q <= {{(DATA_W-BYTE_NUM_W){1'b0}},
                             tx_byte_number_q};
            end
            default: begin
               rd_data_q <= '0;
            end
         endcase
      end else begin
         rd_data_q <= '0;
      end
   end

   // Length of the division about to start, from current settings
   always_comb begin
      split_eff = split_count_q[SPLIT_W-1:0];
      if (split_eff == SPLIT_ZERO) begin
         split_eff = SPLIT_MIN;
      end
      short_div = (step_q < split_eff);
      div_len = {1'b0, base_divisor_q[BASE_W-1:0]}
                + (short_div ? SHORT_ADD : LONG_ADD);
   end

   assign div_end = (cnt_q == CNT_ZERO);

   // Cycle counter within one division; reload at its end so that
   // new settings only act on whole divisions, never mid-period
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         cnt_q <= CNT_ZERO;
      end else if (div_end) begin
         cnt_q <= div_len - CNT_ONE;
      end else begin
         cnt_q <= cnt_q - CNT_ONE;
      end
   end

   // Position in the 4096-division cycle; wraps naturally
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         step_q <= '0;
      end else if (div_end) begin
         step_q <= step_q + STEP_ONE;
      end
   end

   // One master clock wide pulse per completed division
   always_ff @(posedge i_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= div_end;
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_recovered_virtual_clock = pulse_q;
   assign o_tx_cfg.spacing =
      tx_spacing_ch_q[SPACING_LSB +: SPACING_W];
   assign o_tx_cfg.channels_m1 =
      tx_spacing_ch_q[CHANNELS_LSB +: CHANNELS_W];
   assign o_tx_cfg.byte_number = tx_byte_number_q;

endmodule

// file: sim/rx_clk_div_asserts.sv
// Checker for the register port and divider pulse of the clock block.
// Sees only the top module's ports; bound to every instance of it.
`timescale 1ns/1ps
module rx_clk_div_asserts (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rd_data,
   // Outputs
   input wire logic o_recovered_virtual_clock,
   input wire rx_clk_div_pkg::srts_tx_cfg_s o_tx_cfg
);
   import rx_clk_div_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence rd_byte;
      $past(i_rd) && $past(i_addr) == OFF_TX_BYTE_NUMBER;
   endsequence
   a_rd_idle_zero: assert property (o_rd_data != 16'h0000 |-> $past(i_rd))
      else $error("read data outside read slot");
   a_byte_top_zero: assert property (rd_byte |-> o_rd_data[15:9] == 7'h00)
      else $error("byte number top bits not zero");
   a_byte_read_back: assert property (rd_byte
      |-> o_rd_data[8:0] == $past(o_tx_cfg.byte_number))
      else $error("byte number read differs");
   a_chan_read_back: assert property ($past(i_rd) &&
      $past(i_addr) == OFF_TX_SPACING_CH |-> o_rd_data[14:0] ==
      {$past(o_tx_cfg.channels_m1), $past(o_tx_cfg.spacing)})
      else $error("spacing register read differs");
   a_byte_write_lands: assert property (i_wr &&
      i_addr == OFF_TX_BYTE_NUMBER
      |=> o_tx_cfg.byte_number == $past(i_wr_data[8:0]))
      else $error("byte number write lost");
   a_gap_write_lands: assert property (i_wr &&
      i_addr == OFF_TX_SPACING_CH |=> o_tx_cfg.spacing ==
      $past(i_wr_data[7:0]) && o_tx_cfg.channels_m1 == $past(i_wr_data[14:8]))
      else $error("spacing write lost");
   a_cfg_held: assert property (!$past(i_wr) |-> $stable(o_tx_cfg))
      else $error("settings moved without write");
   a_pulse_single: assert property (o_recovered_virtual_clock
      |=> !o_recovered_virtual_clock)
      else $error("divider pulse too long");
   c_pulse: cover property (o_recovered_virtual_clock);
   c_base_wr: cover property (i_wr && i_addr == OFF_BASE_DIVISOR);
   c_rd_data: cover property (rd_byte);
endmodule

bind rx_clock_divider_srts_tx_cfg rx_clk_div_asserts i_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
   .o_recovered_virtual_clock(o_recovered_virtual_clock),
   .o_tx_cfg(o_tx_cfg));

// file: sim/rx_clock_divider_srts_tx_cfg_tb_top.sv
// Self-checking bench for the clock divider and transmit settings.
// Drives the register port directly; no far-side model.
`timescale 1ns/1ps
module rx_clock_divider_srts_tx_cfg_tb_top;
   import rx_clk_div_pkg::*;
   logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, o_rvc;
   logic [15:0] i_addr = 0, i_wr_data = 0, o_rd_data, r, s, c;
   srts_tx_cfg_s o_tx_cfg;
   logic [31:0] seed = 32'h1f51396c;
   int miscompares = 0, checks = 0;
   rx_clock_divider_srts_tx_cfg i_dut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
      .o_rd_data(o_rd_data), .o_recovered_virtual_clock(o_rvc),
      .o_tx_cfg(o_tx_cfg));
   initial begin
      forever #4 i_clk = ~i_clk;
   end
   function automatic logic [15:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction
   // Spacing software must pair with a channel count
   function automatic logic [7:0] gap_of(input logic [15:0] ch);
      return 8'(16'd256 / (ch + 16'd1) - 16'd1);
   endfunction
   task automatic check(input string n, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, d);
      @(posedge i_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      check("rd_data", o_rd_data, exp);
   endtask
   // Counts over any 4096 divisions, so the start phase does not matter
   task automatic measure(input int b, input logic [15:0] sc);
      int g, shorts;
      shorts = 0;
      for (int k = 0; k < 4098; k++) begin
         g = 0;
         do begin
            @(negedge i_clk);
            g++;
         end while (o_rvc !== 1'b1 && g < 100);
         if (k > 1 && g == b + 2) shorts++;
         else if (k > 1) check("gap", g, b + 3);
      end
      check("shorts", shorts, sc);
   endtask
   task automatic finish_test();
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #700us;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      check("cfg", o_tx_cfg, 24'h000177);
      rd(OFF_BASE_DIVISOR, 16'h0000);
      rd(OFF_SPLIT_COUNT, 16'h0fff);
      rd(OFF_TX_SPACING_CH, 16'h0000);
      rd(OFF_TX_BYTE_NUMBER, 16'h0177);
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 16'hff78 : rnd();
         wr(OFF_TX_BYTE_NUMBER, r);
         rd(OFF_TX_BYTE_NUMBER, {7'h00, r[8:0]});
         c = (i == 0) ? 16'd121 : rnd() % 16'd122;
         s = {1'b0, c[6:0], gap_of(c)};
         wr(OFF_TX_SPACING_CH, s);
         rd(OFF_TX_SPACING_CH, s);
         check("cfg", o_tx_cfg, {s[14:0], r[8:0]});
      end
      wr(16'h60ac, rnd());
      rd(16'h60ac, 16'h0000);
      wr(OFF_BASE_DIVISOR, 16'h0000);
      wr(OFF_SPLIT_COUNT, 16'h0001);
      measure(0, 16'h0001);
      wr(OFF_BASE_DIVISOR, 16'h0001);
      wr(OFF_SPLIT_COUNT, 16'h0000);
      measure(1, 16'h0001);
      r = rnd() & 16'h0fff;
      wr(OFF_BASE_DIVISOR, 16'h0002);
      wr(OFF_SPLIT_COUNT, r);
      measure(2, (r == 16'h0000) ? 16'h0001 : r);
      finish_test();
   end
endmodule
